// ==== sfx_cfg.svh ====
// Purpose: constants of the vector floating-point exception unit
// Assumes: 32-bit register bus, 64-bit operand lanes
// Notes: definitions only
`ifndef SFX_CFG_SVH
`define SFX_CFG_SVH

// register byte offsets
`define SFX_CSR_OFFSET 32'h0000_0000
`define SFX_OSCR_OFFSET 32'h0000_0004

// control/status field layout
`define SFX_FLAG_LSB 0
`define SFX_MASK_LSB 7
`define SFX_EXC_W 6
`define SFX_INV_BIT 0
`define SFX_DEN_BIT 1
`define SFX_DZ_BIT 2
`define SFX_OVF_BIT 3
`define SFX_UNF_BIT 4
`define SFX_INX_BIT 5
`define SFX_OS_SUP_BIT 10

// reset values
`define SFX_FLAG_RST 6'h00
`define SFX_MASK_RST 6'h3F

// encodings of special results
`define SFX_QUIET_D 64'h0008_0000_0000_0000
`define SFX_QUIET_S 32'h0040_0000
`define SFX_INDEF_D 64'hFFF8_0000_0000_0000
`define SFX_INDEF_S 32'hFFC0_0000
`define SFX_INT_INDEF_D 64'h8000_0000_0000_0000
`define SFX_INT_INDEF_S 32'h8000_0000
`define SFX_UNORDERED 3'h7

// biased exponents at which integer conversion overflows
`define SFX_INT_LIM_D 11'h43E
`define SFX_INT_LIM_S 8'h9E

`endif

// ==== sfx_pkg.sv ====
// Purpose: types of the vector floating-point exception unit
// Assumes: used with sfx_cfg.svh
// Notes: operation codes are given by the issue logic
package sfx_pkg;

  typedef enum logic [3:0] {
    SFX_OP_PINT = 4'h0,
    SFX_OP_ADD = 4'h1,
    SFX_OP_MUL = 4'h2,
    SFX_OP_DIV = 4'h3,
    SFX_OP_SQRT = 4'h4,
    SFX_OP_MAXMIN = 4'h5,
    SFX_OP_CMP = 4'h6,
    SFX_OP_COMI = 4'h7,
    SFX_OP_CVT_FP = 4'h8,
    SFX_OP_CVT_INT = 4'h9,
    SFX_OP_TRUNC_ST = 4'hA
  } sfx_op_t;

  typedef enum logic [2:0] {
    SFX_PR_EQ = 3'h0,
    SFX_PR_LT = 3'h1,
    SFX_PR_LE = 3'h2,
    SFX_PR_UNORD = 3'h3,
    SFX_PR_NEQ = 3'h4,
    SFX_PR_NLT = 3'h5,
    SFX_PR_NLE = 3'h6,
    SFX_PR_ORD = 3'h7
  } sfx_pred_t;

  typedef enum logic [2:0] {
    SFX_REG_NONE = 3'b001,
    SFX_REG_CSR = 3'b010,
    SFX_REG_OS = 3'b100
  } sfx_reg_t;

  typedef struct packed {
    logic [5:0] flags;
    logic [5:0] masks;
    logic os_sup;
    logic ap_wr;
    sfx_reg_t ap_reg;
    logic [31:0] hrdata;
    logic res_valid;
    logic res_write;
    logic [63:0] res_data;
    logic [2:0] aflags;
    logic aflags_write;
    logic simd_flt;
    logic undef_flt;
  } sfx_state_t;

endpackage

// ==== sfx_class_if.sv ====
// Purpose: operand class bundle between classifier and exception unit
// Assumes: one operand per instance
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
interface sfx_class_if;
  logic sign;
  logic nan;
  logic snan;
  logic inf;
  logic zero;
  logic denorm;
  logic int_ovr;
  modport prod (output sign, nan, snan, inf, zero, denorm, int_ovr);
  modport cons (input sign, nan, snan, inf, zero, denorm, int_ovr);
endinterface
`default_nettype wire

// ==== sfx_classify.sv ====
// Purpose: classify one floating-point operand in single or double format
// Assumes: single values sit in the low 32 bits
// Notes: int_ovr covers nan, infinity and magnitudes beyond the integer range
`timescale 1ns/1ps
`default_nettype none
`include "sfx_cfg.svh"
module sfx_classify (
  // operand
  input wire logic [63:0] opnd_i,
  input wire logic dbl_i,
  // classes
  sfx_class_if.prod cls
);
  logic exp_ones;
  logic exp_zero;
  logic frac_zero;
  logic quiet;
  logic big;

  always_comb begin
    if (dbl_i) begin
      exp_ones = &opnd_i[62:52];
      exp_zero = ~|opnd_i[62:52];
      frac_zero = ~|opnd_i[51:0];
      quiet = opnd_i[51];
      big = opnd_i[62:52] >= `SFX_INT_LIM_D;
      cls.sign = opnd_i[63];
    end else begin
      exp_ones = &opnd_i[30:23];
      exp_zero = ~|opnd_i[30:23];
      frac_zero = ~|opnd_i[22:0];
      quiet = opnd_i[22];
      big = opnd_i[30:23] >= `SFX_INT_LIM_S;
      cls.sign = opnd_i[31];
    end
    cls.nan = exp_ones & ~frac_zero;
    cls.snan = exp_ones & ~frac_zero & ~quiet;
    cls.inf = exp_ones & frac_zero;
    cls.zero = exp_zero & frac_zero;
    cls.denorm = exp_zero & ~frac_zero;
    cls.int_ovr = exp_ones | big;
  end
endmodule
`default_nettype wire

// ==== sfx_unit.sv ====
// Purpose: vector floating-point exception detection, masked results, faults
// Assumes: one lane per issue; datapath result and flags valid with op_valid_i
// Notes: registers on a zero-wait AHB-Lite slave; results one cycle after issue
//
// Behaviour
// - packed integer operations never raise numeric exceptions
// - six exception classes, each flag and mask
// - faults reported with the offending instruction's result
// - truncating stack store raises no vector exception
// - masks writable, masks and flags readable
// - unmasked with OS support raises SIMD fault
// - unmasked without OS support raises undefined-opcode fault
// - invalid flag bit 0, mask bit 7
// - masked invalid value overwrites destination register
// - arithmetic with signalling NaN returns quieted NaN
// - square root of signalling NaN returns quieted
// - square root of negative returns NaN indefinite
// - max/min with any NaN returns source two
// - compare with NaN returns zeros or ones mask
// - precision conversion of signalling NaN returns quieted
// - ordered compare with NaN sets unordered flags
// - opposite infinities added give NaN indefinite
// - infinity times zero, 0/0, inf/inf indefinite
// - bad integer conversion returns integer indefinite
// - unmasked invalid invokes handler, destination untouched
// - ordered compares and relational predicates trap quiet NaN
// - denormal flag bit 1, mask bit 8
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sfx_cfg.svh"
module sfx_unit (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // instruction issue
  input wire logic op_valid_i,
  input wire sfx_pkg::sfx_op_t op_code_i,
  input wire logic op_dbl_i,
  input wire logic op_sub_i,
  input wire sfx_pkg::sfx_pred_t op_pred_i,
  input wire logic [63:0] src1_i,
  input wire logic [63:0] src2_i,
  // datapath results
  input wire logic [63:0] dp_result_i,
  input wire logic [2:0] dp_events_i,
  input wire logic [2:0] dp_aflags_i,
  // completion
  output logic res_valid_o,
  output logic res_write_o,
  output logic [63:0] res_data_o,
  output logic [2:0] aflags_o,
  output logic aflags_write_o,
  output logic simd_fp_fault_o,
  output logic undefined_opcode_fault_o
);
  sfx_pkg::sfx_state_t st_q;
  sfx_pkg::sfx_state_t st_d;

  sfx_class_if ca ();
  sfx_class_if cb ();

  sfx_classify u_cls_a (
    .opnd_i(src1_i),
    .dbl_i(op_dbl_i),
    .cls(ca)
  );
  sfx_classify u_cls_b (
    .opnd_i(src2_i),
    .dbl_i(op_dbl_i),
    .cls(cb)
  );

  logic any_nan;
  logic any_snan;
  logic inv;
  logic dz;
  logic den;
  logic dp_ev;
  logic unmasked;
  logic [5:0] ev;
  logic [63:0] special;
  logic use_special;
  logic rel_pred;
  logic ones_pred;
  logic ap_take;
  logic csr_wr;
  logic os_wr;
  logic no_dest;

  function automatic logic [63:0] quiet_nan(input logic [63:0] v, input logic dbl);
    if (dbl) begin
      quiet_nan = v | `SFX_QUIET_D;
    end else begin
      quiet_nan = {32'h0000_0000, v[31:0] | `SFX_QUIET_S};
    end
  endfunction

  function automatic logic [63:0] fp_indef(input logic dbl);
    fp_indef = dbl ? `SFX_INDEF_D : {32'h0000_0000, `SFX_INDEF_S};
  endfunction

  function automatic logic [31:0] reg_read(input sfx_pkg::sfx_state_t s, input sfx_pkg::sfx_reg_t r);
    reg_read = 32'h0000_0000;
    if (r == sfx_pkg::SFX_REG_CSR) begin
      reg_read[`SFX_FLAG_LSB +: `SFX_EXC_W] = s.flags;
      reg_read[`SFX_MASK_LSB +: `SFX_EXC_W] = s.masks;
    end else if (r == sfx_pkg::SFX_REG_OS) begin
      reg_read[`SFX_OS_SUP_BIT] = s.os_sup;
    end
  endfunction

  assign any_nan = ca.nan | cb.nan;
  assign any_snan = ca.snan | cb.snan;
  assign rel_pred = (op_pred_i == sfx_pkg::SFX_PR_LT) | (op_pred_i == sfx_pkg::SFX_PR_LE) |
                    (op_pred_i == sfx_pkg::SFX_PR_NLT) | (op_pred_i == sfx_pkg::SFX_PR_NLE);
  assign ones_pred = (op_pred_i == sfx_pkg::SFX_PR_NEQ) | (op_pred_i == sfx_pkg::SFX_PR_UNORD) |
                     (op_pred_i == sfx_pkg::SFX_PR_NLT) | (op_pred_i == sfx_pkg::SFX_PR_NLE);
  assign no_dest = (op_code_i == sfx_pkg::SFX_OP_COMI);

  // detection and masked responses per operation
  always_comb begin
    inv = 1'b0;
    dz = 1'b0;
    den = ca.denorm | cb.denorm;
    dp_ev = 1'b0;
    special = 64'h0;
    use_special = 1'b0;
    case (op_code_i)
      sfx_pkg::SFX_OP_ADD: begin
        inv = any_snan | (ca.inf & cb.inf & (ca.sign != (cb.sign ^ op_sub_i)));
        special = any_snan ? quiet_nan(ca.snan ? src1_i : src2_i, op_dbl_i) : fp_indef(op_dbl_i);
        use_special = inv;
        dp_ev = 1'b1;
      end
      sfx_pkg::SFX_OP_MUL: begin
        inv = any_snan | (ca.inf & cb.zero) | (ca.zero & cb.inf);
        special = any_snan ? quiet_nan(ca.snan ? src1_i : src2_i, op_dbl_i) : fp_indef(op_dbl_i);
        use_special = inv;
        dp_ev = 1'b1;
      end
      sfx_pkg::SFX_OP_DIV: begin
        // zero over zero, infinity over infinity
        inv = any_snan | (ca.zero & cb.zero) | (ca.inf & cb.inf);
        dz = cb.zero & ~ca.zero & ~ca.inf & ~ca.nan;
        special = any_snan ? quiet_nan(ca.snan ? src1_i : src2_i, op_dbl_i) : fp_indef(op_dbl_i);
        use_special = inv;
        dp_ev = 1'b1;
      end
      sfx_pkg::SFX_OP_SQRT: begin
        inv = ca.snan | (ca.sign & ~ca.zero & ~ca.nan);
        den = ca.denorm;
        special = ca.snan ? quiet_nan(src1_i, op_dbl_i) : fp_indef(op_dbl_i);
        use_special = inv;
        dp_ev = 1'b1;
      end
      sfx_pkg::SFX_OP_MAXMIN: begin
        inv = any_nan;
        special = src2_i;
        use_special = inv;
      end
      sfx_pkg::SFX_OP_CMP: begin
        inv = any_snan | (any_nan & rel_pred);
        special = (ones_pred & op_dbl_i) ? 64'hFFFF_FFFF_FFFF_FFFF :
                  ones_pred ? 64'h0000_0000_FFFF_FFFF : 64'h0;
        use_special = any_nan;
      end
      sfx_pkg::SFX_OP_COMI: begin
        inv = any_nan;
      end
      sfx_pkg::SFX_OP_CVT_FP: begin
        // quieted NaN in the other precision
        inv = ca.snan;
        den = ca.denorm;
        special = op_dbl_i ? {32'h0000_0000, ca.sign, 8'hFF, src1_i[51:29]} | {32'h0000_0000, `SFX_QUIET_S} :
                  {ca.sign, 11'h7FF, src1_i[22:0], 29'h0} | `SFX_QUIET_D;
        use_special = inv;
        dp_ev = 1'b1;
      end
      sfx_pkg::SFX_OP_CVT_INT: begin
        // no denormal event on integer conversion
        inv = ca.int_ovr;
        den = 1'b0;
        special = op_dbl_i ? `SFX_INT_INDEF_D : {32'h0000_0000, `SFX_INT_INDEF_S};
        use_special = inv;
        dp_ev = 1'b1;
      end
      default: begin
        // integer work and truncating store stay silent
        den = 1'b0;
      end
    endcase
  end

  // one event per class, invalid takes precedence
  always_comb begin
    ev = 6'h00;
    ev[`SFX_INV_BIT] = inv;
    ev[`SFX_DEN_BIT] = den & ~inv;
    ev[`SFX_DZ_BIT] = dz & ~inv;
    ev[`SFX_OVF_BIT] = dp_ev & ~inv & dp_events_i[0];
    ev[`SFX_UNF_BIT] = dp_ev & ~inv & dp_events_i[1];
    ev[`SFX_INX_BIT] = dp_ev & ~inv & dp_events_i[2];
    if (!op_valid_i) begin
      ev = 6'h00;
    end
  end

  assign unmasked = |(ev & ~st_q.masks);
  assign ap_take = hsel_i & htrans_i[1] & hready_i;
  assign csr_wr = st_q.ap_wr & (st_q.ap_reg == sfx_pkg::SFX_REG_CSR);
  assign os_wr = st_q.ap_wr & (st_q.ap_reg == sfx_pkg::SFX_REG_OS);

  always_comb begin
    st_d = st_q;
    // software load of the control/status word
    if (csr_wr) begin
      st_d.flags = hwdata_i[`SFX_FLAG_LSB +: `SFX_EXC_W];
      st_d.masks = hwdata_i[`SFX_MASK_LSB +: `SFX_EXC_W];
    end
    if (os_wr) begin
      st_d.os_sup = hwdata_i[`SFX_OS_SUP_BIT];
    end
    // sticky set wins over a clearing write
    st_d.flags = st_d.flags | ev;
    st_d.ap_wr = 1'b0;
    st_d.ap_reg = sfx_pkg::SFX_REG_NONE;
    if (ap_take) begin
      if (haddr_i == `SFX_CSR_OFFSET) begin
        st_d.ap_reg = sfx_pkg::SFX_REG_CSR;
      end else if (haddr_i == `SFX_OSCR_OFFSET) begin
        st_d.ap_reg = sfx_pkg::SFX_REG_OS;
      end
      st_d.ap_wr = hwrite_i;
    end
    // read sees this cycle's updates, so a write then read is coherent
    st_d.hrdata = reg_read(st_d, st_d.ap_reg);
    // completion carries its own fault in the same cycle
    st_d.res_valid = op_valid_i;
    // masked results overwrite, unmasked leave the destination
    st_d.res_write = op_valid_i & ~unmasked & ~no_dest;
    st_d.res_data = use_special ? special : dp_result_i;
    st_d.aflags = any_nan ? `SFX_UNORDERED : dp_aflags_i;
    st_d.aflags_write = op_valid_i & no_dest & ~unmasked;
    st_d.simd_flt = op_valid_i & unmasked & st_q.os_sup;
    st_d.undef_flt = op_valid_i & unmasked & ~st_q.os_sup;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
      st_q.flags <= `SFX_FLAG_RST;
      st_q.masks <= `SFX_MASK_RST;
      st_q.ap_reg <= sfx_pkg::SFX_REG_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = st_q.hrdata;
  assign res_valid_o = st_q.res_valid;
  assign res_write_o = st_q.res_write;
  assign res_data_o = st_q.res_data;
  assign aflags_o = st_q.aflags;
  assign aflags_write_o = st_q.aflags_write;
  assign simd_fp_fault_o = st_q.simd_flt;
  assign undefined_opcode_fault_o = st_q.undef_flt;

  default clocking cb_main @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_unmasked_issue;
    op_valid_i && unmasked;
  endsequence

  sequence s_fault_done;
    res_valid_o && !res_write_o && (simd_fp_fault_o ^ undefined_opcode_fault_o);
  endsequence

  chk_int_silent: assert property (
    op_valid_i && op_code_i == sfx_pkg::SFX_OP_PINT |=> res_write_o && !simd_fp_fault_o && !undefined_opcode_fault_o
  ) else $error("packed integer op raised a fault");

  chk_trunc_silent: assert property (
    op_valid_i && op_code_i == sfx_pkg::SFX_OP_TRUNC_ST && !csr_wr |=> st_q.flags == $past(st_q.flags)
  ) else $error("truncating store changed vector flags");

  chk_fault_precise: assert property (
    s_unmasked_issue |=> s_fault_done
  ) else $error("unmasked exception not reported with its instruction");

  chk_simd_with_os: assert property (
    s_unmasked_issue and st_q.os_sup |=> simd_fp_fault_o && !undefined_opcode_fault_o
  ) else $error("missing simd fault");

  chk_undef_without_os: assert property (
    s_unmasked_issue and !st_q.os_sup |=> undefined_opcode_fault_o && !simd_fp_fault_o
  ) else $error("missing undefined-opcode fault");

  chk_invalid_flag_pos: assert property (
    op_valid_i && inv |=> st_q.flags[0] && (st_q.hrdata[7] == $past(st_q.hrdata[7]) || $past(st_q.ap_reg) != 3'b010)
  ) else $error("invalid flag not set at bit 0");

  chk_flag_sticky: assert property (
    !csr_wr |=> ($past(st_q.flags) & ~st_q.flags) == 6'h00
  ) else $error("flag cleared without a software write");

  chk_sqrt_indef: assert property (
    op_valid_i && op_code_i == sfx_pkg::SFX_OP_SQRT && op_dbl_i && ca.sign && !ca.zero && !ca.nan
      && st_q.masks[0] |=> res_write_o && res_data_o == 64'hFFF8_0000_0000_0000
  ) else $error("square root of negative did not give indefinite");

  chk_maxmin_src2: assert property (
    op_valid_i && op_code_i == sfx_pkg::SFX_OP_MAXMIN && any_nan && st_q.masks[0] |=> res_data_o == $past(src2_i)
  ) else $error("max/min with NaN did not return source two");

  chk_comi_unord: assert property (
    op_valid_i && op_code_i == sfx_pkg::SFX_OP_COMI && any_nan && st_q.masks[0] |=> aflags_write_o && aflags_o == 3'h7
  ) else $error("ordered compare with NaN not unordered");

  chk_unmasked_keep: assert property (
    op_valid_i && inv && !st_q.masks[0] |=> !res_write_o && !aflags_write_o
  ) else $error("unmasked invalid wrote a destination");

endmodule
`default_nettype wire

// ==== sfx_unit_tb.sv ====
// Purpose: self-checking bench of the vector floating-point exception unit
// Assumes: zero-wait register bus; completion one cycle after issue
// Notes: single results are judged on the low word only
`timescale 1ns/1ps
`default_nettype none
`include "sfx_cfg.svh"
module sfx_unit_tb;
  localparam logic [31:0] A_CSR = `SFX_CSR_OFFSET;
  localparam logic [31:0] A_OS = `SFX_OSCR_OFFSET;
  localparam logic [63:0] SNAN = 64'h7FF4_0000_0000_0000;
  localparam logic [63:0] QNAN = 64'h7FF8_0000_0000_0000;
  localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] PINF = 64'h7FF0_0000_0000_0000;
  localparam logic [63:0] NINF = 64'hFFF0_0000_0000_0000;
  localparam logic [63:0] ALL = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] LO = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] DPR = 64'h1234_5678_9ABC_DEF0;
  // built from the field layout so a wrong shared constant is still caught
  localparam logic [63:0] INDEF = {1'b1, 11'h7FF, 1'b1, 51'h0};
  // nan as a double and infinity in the low word: out of range for either source width
  localparam logic [63:0] BADINT = 64'h7FF0_0000_7F80_0000;
  localparam sfx_pkg::sfx_op_t PINT = sfx_pkg::SFX_OP_PINT, ADD = sfx_pkg::SFX_OP_ADD, MUL = sfx_pkg::SFX_OP_MUL;
  localparam sfx_pkg::sfx_op_t DIV = sfx_pkg::SFX_OP_DIV, SQRT = sfx_pkg::SFX_OP_SQRT, CMP = sfx_pkg::SFX_OP_CMP;
  localparam sfx_pkg::sfx_op_t MAXMIN = sfx_pkg::SFX_OP_MAXMIN, COMI = sfx_pkg::SFX_OP_COMI;
  localparam sfx_pkg::sfx_op_t CVTFP = sfx_pkg::SFX_OP_CVT_FP, CVTINT = sfx_pkg::SFX_OP_CVT_INT;
  localparam sfx_pkg::sfx_op_t TRUNC = sfx_pkg::SFX_OP_TRUNC_ST;

  logic core_clk = 1'b0;
  logic reset_n;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, dp_events, dp_aflags, aflags;
  logic op_valid, op_dbl, op_sub, cur_sub;
  sfx_pkg::sfx_op_t op_code;
  sfx_pkg::sfx_pred_t op_pred, cur_pred;
  logic [63:0] src1, src2, dp_result, res_data;
  logic res_valid, res_write, aflags_write, simd_flt, undef_flt;
  int n_errors = 0;
  int checks_done = 0;

  always #5 core_clk = ~core_clk;

  sfx_unit dut (
    .core_clk_i(core_clk), .reset_n_i(reset_n),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .op_valid_i(op_valid), .op_code_i(op_code), .op_dbl_i(op_dbl), .op_sub_i(op_sub), .op_pred_i(op_pred),
    .src1_i(src1), .src2_i(src2), .dp_result_i(dp_result), .dp_events_i(dp_events), .dp_aflags_i(dp_aflags),
    .res_valid_o(res_valid), .res_write_o(res_write), .res_data_o(res_data), .aflags_o(aflags),
    .aflags_write_o(aflags_write), .simd_fp_fault_o(simd_flt), .undefined_opcode_fault_o(undef_flt)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({63'h0, got}, {63'h0, exp});
  endtask

  function automatic logic [31:0] csr(input logic [5:0] m, input logic [5:0] f);
    csr = {19'h0, m, 1'b0, f};
  endfunction

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      $display("unexpected at %0t: ready stuck, got %h expected %h", $time, hreadyout, 1'b1);
      finish_test();
    end
  endtask

  // hsel stays high: dropping it at the data edge would collide with the next address phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic bus_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk_val({32'h0, rd}, {32'h0, exp});
    chk_bit(hresp, 1'b0);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // flt is {simd fault, undefined-opcode fault}; cmp_mask of zero skips the destination checks
  task automatic run_op(input sfx_pkg::sfx_op_t op, input logic dbl, input logic [63:0] a, input logic [63:0] b,
                        input logic [2:0] ev, input logic [63:0] exp_d, input logic [63:0] cmp_mask,
                        input logic [1:0] flt);
    op_code <= op;
    op_dbl <= dbl;
    op_sub <= cur_sub;
    op_pred <= cur_pred;
    src1 <= a;
    src2 <= b;
    dp_events <= ev;
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    // completion launched at the issue edge still stands at the next one
    @(posedge core_clk);
    chk_bit(res_valid, 1'b1);
    chk_bit(simd_flt, flt[1]);
    chk_bit(undef_flt, flt[0]);
    chk_bit(aflags_write, op == COMI && flt == 2'b00);
    if (cmp_mask != 64'h0) begin
      chk_bit(res_write, flt == 2'b00);
      if (flt == 2'b00) chk_val(res_data & cmp_mask, exp_d & cmp_mask);
    end
  endtask

  task automatic t_reset_regs();
    bus_chk(A_CSR, csr(6'h3F, 6'h00));
    bus_chk(A_OS, 32'h0);
    bus_wr(32'h0000_0008, 32'hFFFF_FFFF);
    bus_chk(32'h0000_0008, 32'h0);
    $display("test reset_regs done");
  endtask

  task automatic t_masked();
    run_op(ADD, 1'b1, SNAN, ONE, 3'h0, SNAN | `SFX_QUIET_D, ALL, 2'b00);
    run_op(SQRT, 1'b0, 64'h7F80_0001, 64'h0, 3'h0, 64'h7FC0_0001, LO, 2'b00);
    run_op(SQRT, 1'b1, 64'hBFF0_0000_0000_0000, 64'h0, 3'h0, INDEF, ALL, 2'b00);
    run_op(MAXMIN, 1'b1, QNAN, ONE, 3'h0, ONE, ALL, 2'b00);
    run_op(CVTFP, 1'b1, SNAN, 64'h0, 3'h0, 64'h7FE0_0000, LO, 2'b00);
    run_op(CVTFP, 1'b0, 64'h7FA0_0000, 64'h0, 3'h0, SNAN | `SFX_QUIET_D, ALL, 2'b00);
    run_op(ADD, 1'b1, PINF, NINF, 3'h0, INDEF, ALL, 2'b00);
    cur_sub = 1'b1;
    run_op(ADD, 1'b1, PINF, PINF, 3'h0, INDEF, ALL, 2'b00);
    cur_sub = 1'b0;
    run_op(MUL, 1'b1, PINF, 64'h0, 3'h0, INDEF, ALL, 2'b00);
    run_op(DIV, 1'b1, 64'h0, 64'h0, 3'h0, INDEF, ALL, 2'b00);
    run_op(DIV, 1'b1, PINF, PINF, 3'h0, INDEF, ALL, 2'b00);
    run_op(CVTINT, 1'b0, BADINT, 64'h0, 3'h0, 64'h8000_0000, LO, 2'b00);
    run_op(CVTINT, 1'b1, BADINT, 64'h0, 3'h0, 64'h8000_0000_0000_0000, ALL, 2'b00);
    run_op(COMI, 1'b1, QNAN, ONE, 3'h0, 64'h0, 64'h0, 2'b00);
    chk_val({61'h0, aflags}, 64'h7);
    // unord, neq, nlt and nle give ones; every other predicate zeros
    for (int p = 0; p < 8; p++) begin
      cur_pred = sfx_pkg::sfx_pred_t'(p);
      run_op(CMP, 1'b1, QNAN, ONE, 3'h0, (p >= 3 && p <= 6) ? ALL : 64'h0, ALL, 2'b00);
    end
    cur_pred = sfx_pkg::SFX_PR_EQ;
    bus_chk(A_CSR, csr(6'h3F, 6'h01));
    $display("test masked done");
  endtask

  task automatic t_flags();
    bus_wr(A_CSR, csr(6'h3F, 6'h00));
    bus_chk(A_CSR, csr(6'h3F, 6'h00));
    run_op(ADD, 1'b1, ONE, ONE, 3'h7, DPR, ALL, 2'b00);
    run_op(DIV, 1'b1, ONE, 64'h0, 3'h0, DPR, ALL, 2'b00);
    run_op(ADD, 1'b1, 64'h1, ONE, 3'h0, DPR, ALL, 2'b00);
    bus_chk(A_CSR, csr(6'h3F, 6'h3E));
    run_op(PINT, 1'b1, SNAN, 64'h1, 3'h7, DPR, ALL, 2'b00);
    run_op(TRUNC, 1'b1, SNAN, 64'h1, 3'h0, 64'h0, 64'h0, 2'b00);
    bus_chk(A_CSR, csr(6'h3F, 6'h3E));
    $display("test flags done");
  endtask

  task automatic t_qnan();
    bus_wr(A_CSR, csr(6'h3F, 6'h00));
    run_op(CMP, 1'b1, QNAN, ONE, 3'h0, 64'h0, ALL, 2'b00);
    bus_chk(A_CSR, csr(6'h3F, 6'h00));
    cur_pred = sfx_pkg::SFX_PR_LT;
    run_op(CMP, 1'b1, QNAN, ONE, 3'h0, 64'h0, ALL, 2'b00);
    cur_pred = sfx_pkg::SFX_PR_EQ;
    bus_chk(A_CSR, csr(6'h3F, 6'h01));
    $display("test qnan done");
  endtask

  task automatic t_unmasked();
    bus_wr(A_CSR, csr(6'h00, 6'h00));
    bus_chk(A_CSR, csr(6'h00, 6'h00));
    run_op(ADD, 1'b1, SNAN, ONE, 3'h0, 64'h0, ALL, 2'b01);
    run_op(PINT, 1'b1, SNAN, QNAN, 3'h7, DPR, ALL, 2'b00);
    run_op(TRUNC, 1'b1, SNAN, QNAN, 3'h7, 64'h0, 64'h0, 2'b00);
    bus_wr(A_OS, 32'h0000_0400);
    bus_chk(A_OS, 32'h0000_0400);
    run_op(ADD, 1'b1, SNAN, ONE, 3'h0, 64'h0, ALL, 2'b10);
    run_op(COMI, 1'b1, QNAN, ONE, 3'h0, 64'h0, 64'h0, 2'b10);
    run_op(MUL, 1'b1, ONE, ONE, 3'h1, 64'h0, ALL, 2'b10);
    bus_wr(A_CSR, csr(6'h01, 6'h00));
    run_op(ADD, 1'b1, SNAN, ONE, 3'h0, SNAN | `SFX_QUIET_D, ALL, 2'b00);
    run_op(MUL, 1'b1, ONE, ONE, 3'h1, 64'h0, ALL, 2'b10);
    $display("test unmasked done");
  endtask

  initial begin
    reset_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    op_valid = 1'b0;
    op_code = PINT;
    op_dbl = 1'b0;
    op_sub = 1'b0;
    cur_sub = 1'b0;
    op_pred = sfx_pkg::SFX_PR_EQ;
    cur_pred = sfx_pkg::SFX_PR_EQ;
    src1 = 64'h0;
    src2 = 64'h0;
    dp_result = DPR;
    dp_events = 3'h0;
    dp_aflags = 3'h2;
    do_reset();
    t_reset_regs();
    t_masked();
    t_flags();
    t_qnan();
    t_unmasked();
    // second reset in mid-run must restore masks and clear the handler-support bit
    do_reset();
    t_reset_regs();
    finish_test();
  end
endmodule
`default_nettype wire
